// ### core/irdr_defines.svh
`ifndef IRDR_DEFINES_SVH
`define IRDR_DEFINES_SVH
// Array identifiers
`define IRDR_ID_ITAG   8'h00
`define IRDR_ID_IDATA  8'h01
`define IRDR_ID_ITLB   8'h04
`define IRDR_ID_MOP    8'h06
`define IRDR_ID_DTAG   8'h08
`define IRDR_ID_DDATA  8'h09
`define IRDR_ID_DTLB   8'h0A
// Index operand fields
`define IRDR_ID_HI     31
`define IRDR_ID_LO     24
`define IRDR_WAY_HI    19
`define IRDR_WAY_LO    18
`define IRDR_SUB_HI    17
`define IRDR_SUB_LO    16
`define IRDR_COPY_RSVD 2'h3
// Result reset value
`define IRDR_RESULT_RST 64'h0000000000000000
// Result register select codes
`define IRDR_SEL_D0    3'h0
`define IRDR_SEL_D1    3'h1
`define IRDR_SEL_D2    3'h2
`define IRDR_SEL_I0    3'h4
`define IRDR_SEL_I1    3'h5
`define IRDR_SEL_I2    3'h6
`endif

// ### core/irdr_internal_ram_debug_read.sv
// Functional notes
// - Read-only view; no path writes any cache or TLB entry.
// - Accesses allowed only at top privilege level; otherwise undefined-instruction fault.
// - Index bits 31:24 carry the array identifier, decoded to choose array.
// - Three data-side and three instruction-side read-only 64-bit results.
// - Both first-level caches are four-way; way field two bits.
// - Identifier 0x00 reads instruction tag; way 19:18, VA 13:6.
// - Identifier 0x01 reads instruction data; way 19:18, VA 13:3.
// - Identifier 0x04 reads instruction TLB; entry from bits 7:0.
// - Identifier 0x06 reads macro-op cache; ten-bit index bits 9:0.
// - Identifier 0x08 reads data tag; way, copy 17:16 (3 reserved), PA 13:6.
// - Identifier 0x09 reads data data; way, bank choice 17:16, PA 13:6.
// - Identifier 0x0A reads data TLB; entry from bits 5:0.
// - Instruction tag word0: NS 31, PA 30:3, state 2:1, parity 0.
// - Instruction tag words 1 and 2 read reserved zero.
// - Instruction data: word0 bits 63:0, word1 bits 83:64, word2 zero.
// - ITLB word0: VA12 at 63, attributes 62:59, memtype 57:55, size 54:52.
// - ITLB memory type 000-011 device, 100 NC, 101-111 write-back kinds.
// - ITLB word0: shareable 51:50, zero 49:42, address/VM/mode tags, valid 0.
`include "irdr_defines.svh"
module irdr_internal_ram_debug_read
  import irdr_pkg::*;
#(
  parameter int ITAG_W = 32,
  parameter int ITLB_W = 64
) (
  input  wire logic         clock,
  input  wire logic         arst_n,
  input  wire irdr_req_s    req,
  output logic              busy,
  output logic              undefFault,
  output logic [63:0]       rdata,
  output logic              arrayReq,
  output logic [7:0]        arrayIdentifier,
  output logic [1:0]        wayField,
  output logic [1:0]        subField,
  output logic [10:0]       setIndex,
  input  wire logic         arrayAck,
  input  wire logic [ITAG_W-1:0] iTagWord,
  input  wire logic [83:0]  iDataWord,
  input  wire logic [ITLB_W-1:0] iTlbWord,
  input  wire irdr_result_s mopResult,
  input  wire irdr_result_s dResult
);
  ////////////////////////////////////////////////////////////////////////////
  irdr_state_e  state;
  irdr_state_e  next_state;
  irdr_result_s iRes;
  irdr_result_s dRes;
  logic [31:0]  index;

  wire       topLevel   = (req.el == 2'h3);
  wire       legal      = req.valid && topLevel;
  wire       idxWrite   = legal && req.write && (state != IRDR_WAIT);
  wire       resRead    = legal && !req.write;
  wire [7:0] curId      = index[`IRDR_ID_HI:`IRDR_ID_LO];
  // Way is two bits since both caches are four-way
  wire [1:0] curWay     = index[`IRDR_WAY_HI:`IRDR_WAY_LO];
  wire [1:0] curSub     = index[`IRDR_SUB_HI:`IRDR_SUB_LO];
  // Reserved tag copy is never launched; it returns zeros
  wire       copyRsvd   = (curId == `IRDR_ID_DTAG) && (curSub == `IRDR_COPY_RSVD);

  ////////////////////////////////////////////////////////////////////////////
  // Location decode per array
  logic [10:0] locIdx;
  always_comb begin
    case (curId)
      `IRDR_ID_ITAG:  locIdx = {3'h0, index[13:6]};
      `IRDR_ID_IDATA: locIdx = index[13:3];
      `IRDR_ID_ITLB:  locIdx = {3'h0, index[7:0]};
      `IRDR_ID_MOP:   locIdx = {1'h0, index[9:0]};
      `IRDR_ID_DTAG:  locIdx = {3'h0, index[13:6]};
      `IRDR_ID_DDATA: locIdx = {3'h0, index[13:6]};
      `IRDR_ID_DTLB:  locIdx = {5'h00, index[5:0]};
      default:        locIdx = 11'h000;
    endcase
  end

  // Read-only array port: address and request only, never write data
  assign arrayReq        = (state == IRDR_WAIT) && !copyRsvd;
  assign arrayIdentifier = curId;
  assign wayField        = curWay;
  assign subField        = ((curId == `IRDR_ID_DTAG) || (curId == `IRDR_ID_DDATA)) ? curSub : 2'h0;
  assign setIndex        = locIdx;

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting
  logic [63:0] iTlb0;
  // Bits not named in the formats are forced zero; [49:42] explicitly zero
  assign iTlb0 = {iTlbWord[63], iTlbWord[62:59], 1'h0, iTlbWord[57:55],
                  iTlbWord[54:52], iTlbWord[51:50], 8'h00, 2'h0,
                  iTlbWord[39:24], iTlbWord[23:8], iTlbWord[7:5], 4'h0, iTlbWord[0]};

  irdr_result_s next_iRes;
  irdr_result_s next_dRes;
  always_comb begin
    next_iRes = '0;
    next_dRes = '0;
    case (curId)
      `IRDR_ID_ITAG: begin
        next_iRes.word0 = {32'h0, iTagWord[31], iTagWord[30:3], iTagWord[2:1], iTagWord[0]};
      end
      `IRDR_ID_IDATA: begin
        next_iRes.word0 = iDataWord[63:0];
        next_iRes.word1 = {44'h0, iDataWord[83:64]};
      end
      `IRDR_ID_ITLB:  next_iRes.word0 = iTlb0;
      `IRDR_ID_MOP:   next_iRes = mopResult;
      `IRDR_ID_DTAG:  next_dRes = copyRsvd ? '0 : dResult;
      `IRDR_ID_DDATA: next_dRes = dResult;
      `IRDR_ID_DTLB:  next_dRes = dResult;
      default: begin
        next_iRes = '0;
        next_dRes = '0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  wire captureNow = (state == IRDR_WAIT) && (arrayAck || copyRsvd);
  always_comb begin
    next_state = state;
    case (state)
      IRDR_IDLE, IRDR_DONE: if (idxWrite) next_state = IRDR_WAIT;
      IRDR_WAIT:            if (captureNow) next_state = IRDR_DONE;
      default:              next_state = IRDR_IDLE;
    endcase
  end

  wire curIsI = (curId == `IRDR_ID_ITAG) || (curId == `IRDR_ID_IDATA) ||
                (curId == `IRDR_ID_ITLB) || (curId == `IRDR_ID_MOP);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= IRDR_IDLE;
      index <= 32'h0000_0000;
    end else begin
      state <= next_state;
      if (idxWrite) index <= req.wdata;
    end
  end

  // Captured once per index write and held until the next one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      iRes <= {3{`IRDR_RESULT_RST}};
      dRes <= {3{`IRDR_RESULT_RST}};
    end else if (captureNow) begin
      if (curIsI) iRes <= next_iRes;
      else        dRes <= next_dRes;
    end
  end

  // Reads are dropped while busy; rdata keeps its last value until a read after the capture
  assign busy = (state == IRDR_WAIT);

  // Unprivileged access only pulses the fault; nothing else moves
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) undefFault <= 1'b0;
    else         undefFault <= req.valid && !topLevel;
  end

  logic [63:0] next_rdata;
  always_comb begin
    case (req.sel)
      `IRDR_SEL_D0: next_rdata = dRes.word0;
      `IRDR_SEL_D1: next_rdata = dRes.word1;
      `IRDR_SEL_D2: next_rdata = dRes.word2;
      `IRDR_SEL_I0: next_rdata = iRes.word0;
      `IRDR_SEL_I1: next_rdata = iRes.word1;
      `IRDR_SEL_I2: next_rdata = iRes.word2;
      default:      next_rdata = 64'h0000000000000000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)                 rdata <= `IRDR_RESULT_RST;
    else if (resRead && !busy)   rdata <= next_rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_fault_lowlevel: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.el != 2'h3 |=> undefFault) else $error("no fault on low level");
  a_no_fault_top: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.el == 2'h3 |=> !undefFault) else $error("fault at top level");
  a_write_starts: assert property (@(posedge clock) disable iff (!arst_n)
    idxWrite |=> busy) else $error("index write did not start read");
  a_hold_results: assert property (@(posedge clock) disable iff (!arst_n)
    !captureNow |=> $stable(iRes) && $stable(dRes)) else $error("results changed");
  a_itag_upper: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITAG |=> iRes.word1 == 64'h0 && iRes.word2 == 64'h0)
    else $error("itag upper words not zero");
  a_idata_word1: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_IDATA |=> iRes.word1[63:20] == 44'h0 && iRes.word2 == 64'h0)
    else $error("idata upper bits not zero");
  a_itlb_zero: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[49:42] == 8'h00)
    else $error("itlb zero field set");
  a_rsvd_copy: assert property (@(posedge clock) disable iff (!arst_n)
    busy && copyRsvd |-> !arrayReq ##1 !busy) else $error("reserved copy launched");
  a_idata_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_IDATA |-> setIndex == index[13:3]) else $error("bad idata index");
  c_itag_read: cover property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITAG);
  c_dtlb_read: cover property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_DTLB);
  c_fault: cover property (@(posedge clock) disable iff (!arst_n) undefFault);
  c_back_to_back: cover property (@(posedge clock) disable iff (!arst_n)
    captureNow ##1 idxWrite);
  c_rsvd_copy: cover property (@(posedge clock) disable iff (!arst_n)
    captureNow && copyRsvd);

  ////////////////////////////////////////////////////////////////////////////
  // Shadows of the raw array words; only the assertions read them
  logic [31:0] seenTag;
  logic [83:0] seenData;
  logic [63:0] seenTlb;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      seenTag  <= 32'h0000_0000;
      seenData <= 84'h0;
      seenTlb  <= 64'h0000_0000_0000_0000;
    end else if (captureNow) begin
      seenTag  <= iTagWord[31:0];
      seenData <= iDataWord;
      seenTlb  <= iTlbWord[63:0];
    end
  end

  wire curKnown = curIsI || (curId == `IRDR_ID_DTAG) || (curId == `IRDR_ID_DDATA) ||
                  (curId == `IRDR_ID_DTLB);

  // Sequencing and hold
  a_capture_ends: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow |=> !busy && !arrayReq)
    else $error("read did not finish after capture");
  a_busy_write_drop: assert property (@(posedge clock) disable iff (!arst_n)
    busy && req.valid && req.write |=> $stable(index))
    else $error("index changed while busy");
  a_busy_from_write: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(busy) |-> $past(idxWrite))
    else $error("busy rose without index write");
  a_rdata_hold: assert property (@(posedge clock) disable iff (!arst_n)
    !(resRead && !busy) |=> $stable(rdata))
    else $error("rdata moved without a read");

  // Result register selection
  a_read_d0: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_D0 |=> rdata == dRes.word0)
    else $error("data word0 read wrong");
  a_read_d1: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_D1 |=> rdata == dRes.word1)
    else $error("data word1 read wrong");
  a_read_d2: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_D2 |=> rdata == dRes.word2)
    else $error("data word2 read wrong");
  a_read_i0: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_I0 |=> rdata == iRes.word0)
    else $error("instr word0 read wrong");
  a_read_i1: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_I1 |=> rdata == iRes.word1)
    else $error("instr word1 read wrong");
  a_read_i2: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && req.sel == `IRDR_SEL_I2 |=> rdata == iRes.word2)
    else $error("instr word2 read wrong");
  a_read_unused: assert property (@(posedge clock) disable iff (!arst_n)
    resRead && !busy && (req.sel == 3'h3 || req.sel == 3'h7) |=> rdata == 64'h0)
    else $error("unused select not zero");

  // Array location decode
  a_id_field: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq |-> arrayIdentifier == index[31:24])
    else $error("bad array identifier");
  a_way_field: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq |-> wayField == index[19:18])
    else $error("bad way field");
  a_isub_zero: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curIsI |-> subField == 2'h0)
    else $error("instr array got a sub field");
  a_itag_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_ITAG |-> setIndex == {3'h0, index[13:6]})
    else $error("bad itag index");
  a_itlb_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_ITLB |-> setIndex == {3'h0, index[7:0]})
    else $error("bad itlb entry");
  a_mop_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_MOP |-> setIndex == {1'h0, index[9:0]})
    else $error("bad macro_op index");
  a_dtag_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_DTAG |-> setIndex == {3'h0, index[13:6]} && subField == index[17:16])
    else $error("bad dtag location");
  a_ddata_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_DDATA |-> setIndex == {3'h0, index[13:6]} && subField == index[17:16])
    else $error("bad ddata location");
  a_dtlb_loc: assert property (@(posedge clock) disable iff (!arst_n)
    arrayReq && curId == `IRDR_ID_DTLB |-> setIndex == {5'h00, index[5:0]})
    else $error("bad dtlb entry");

  // Result formats
  a_itag_word0: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITAG |=> iRes.word0 == {32'h0000_0000, seenTag})
    else $error("itag word0 format wrong");
  a_idata_words: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_IDATA |=> iRes.word0 == seenData[63:0] && iRes.word1[19:0] == seenData[83:64])
    else $error("idata words wrong");
  a_itlb_va_attr: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[63:59] == seenTlb[63:59] && !iRes.word0[58])
    else $error("itlb address or attributes wrong");
  a_itlb_type_size: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[57:52] == seenTlb[57:52])
    else $error("itlb type or size wrong");
  a_itlb_share: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[51:50] == seenTlb[51:50])
    else $error("itlb shareable bits wrong");
  a_itlb_tags: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[39:5] == seenTlb[39:5])
    else $error("itlb tags wrong");
  a_itlb_valid: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_ITLB |=> iRes.word0[0] == seenTlb[0] && iRes.word0[4:1] == 4'h0)
    else $error("itlb valid bit wrong");
  a_mop_pass: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_MOP |=> iRes == $past(mopResult))
    else $error("macro_op words wrong");
  a_dside_pass: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && (curId == `IRDR_ID_DDATA || curId == `IRDR_ID_DTLB) |=> dRes == $past(dResult))
    else $error("data side words wrong");
  a_dtag_pass: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curId == `IRDR_ID_DTAG && !copyRsvd |=> dRes == $past(dResult))
    else $error("dtag words wrong");
  a_rsvd_zero: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && copyRsvd |=> dRes == '0)
    else $error("reserved copy not zero");
  a_unknown_zero: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && !curKnown |=> dRes == '0)
    else $error("unknown array not zero");
  a_iside_keep: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && curIsI |=> $stable(dRes))
    else $error("instr read touched data side");
  a_dside_keep: assert property (@(posedge clock) disable iff (!arst_n)
    captureNow && !curIsI |=> $stable(iRes))
    else $error("data read touched instr side");

  // Privilege
  a_fault_quiet: assert property (@(posedge clock) disable iff (!arst_n)
    !req.valid |=> !undefFault)
    else $error("fault without access");
  a_fault_no_effect: assert property (@(posedge clock) disable iff (!arst_n)
    req.valid && req.el != 2'h3 |=> $stable(index) && $stable(rdata))
    else $error("unprivileged access had effect");
endmodule : irdr_internal_ram_debug_read

// ### core/irdr_pkg.sv
package irdr_pkg;
  typedef enum logic [1:0] {IRDR_IDLE, IRDR_WAIT, IRDR_DONE} irdr_state_e;
  typedef struct packed {
    logic [63:0] word0;
    logic [63:0] word1;
    logic [63:0] word2;
  } irdr_result_s;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [2:0]  sel;
    logic [1:0]  el;
    logic [31:0] wdata;
  } irdr_req_s;
endpackage : irdr_pkg

// ### verification/internal_ram_debug_read_bench.sv
`include "irdr_defines.svh"
`define BC_CHK(nm, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("BAD %s expected=%h seen=%h", nm, e, a); end end
module internal_ram_debug_read_bench
  import irdr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clock = 1'b0;
  logic         arstN;
  irdr_req_s    req;
  logic         arrayAck;
  logic [31:0]  iTag, sTag;
  logic [83:0]  iData, sData;
  logic [63:0]  iTlb, sTlb, e;
  irdr_result_s macro_op, dRes, sMop, sD;
  wire logic        busy, fault, aReq;
  wire logic [63:0] rdata;
  wire logic [7:0]  aId;
  wire logic [1:0]  way, sub;
  wire logic [10:0] setIdx;
  logic [63:0]  expQ[$];
  int           miscompares = 0;
  int           num_checks = 0;
  logic         pendRd = 1'b0;
  logic         pendF = 1'b0;
  irdr_internal_ram_debug_read dut_u (.clock(clock), .arst_n(arstN), .req(req), .busy(busy), .undefFault(fault),
    .rdata(rdata), .arrayReq(aReq), .arrayIdentifier(aId), .wayField(way), .subField(sub), .setIndex(setIdx),
    .arrayAck(arrayAck), .iTagWord(iTag), .iDataWord(iData), .iTlbWord(iTlb), .mopResult(macro_op), .dResult(dRes));
  always #2 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: results land one edge after the request, so sample mid-cycle
  always @(posedge clock) begin
    pendRd <= req.valid && !req.write && req.el == 2'h3 && !busy;
    pendF  <= req.valid && req.el != 2'h3;
  end
  always @(negedge clock) begin
    `BC_CHK("undefFault", pendF, fault)
    if (pendRd) begin
      e = expQ.pop_front();
      `BC_CHK("rdata", e, rdata)
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic scramble();
    iTag  = $urandom;
    iData = 84'({$urandom, $urandom, $urandom});
    iTlb  = {$urandom, $urandom};
    macro_op   = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
    dRes  = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
  endtask : scramble
  task automatic send(input logic w, input logic [2:0] s, input logic [1:0] el, input logic [31:0] d);
    @(posedge clock);
    #1 req = '{1'b1, w, s, el, d};
    @(posedge clock);
    #1 req.valid = 1'b0;
  endtask : send
  task automatic rd(input logic [2:0] s, input logic [63:0] ex);
    expQ.push_back(ex);
    send(1'b0, s, 2'h3, 32'h0);
  endtask : rd
  // Index write, then answer the array fetch and keep a copy of what was offered
  task automatic ix(input logic [7:0] id, input logic [1:0] sb, input logic ack);
    logic [31:0] d;
    int          n;
    logic [10:0] loc;
    d = {id, 4'h0, 2'($urandom), sb, 16'($urandom) & 16'h3FFF};
    case (id)
      `IRDR_ID_ITAG, `IRDR_ID_DTAG, `IRDR_ID_DDATA: loc = {3'h0, d[13:6]};
      `IRDR_ID_IDATA: loc = d[13:3];
      `IRDR_ID_ITLB:  loc = {3'h0, d[7:0]};
      `IRDR_ID_MOP:   loc = {1'h0, d[9:0]};
      `IRDR_ID_DTLB:  loc = {5'h00, d[5:0]};
      default:        loc = 11'h000;
    endcase
    send(1'b1, 3'h0, 2'h3, d);
    `BC_CHK("busy", 1'b1, busy)
    `BC_CHK("arrayReq", ack, aReq)
    `BC_CHK("setIndex", loc, setIdx)
    if (ack) begin
      `BC_CHK("arrayIdentifier", id, aId)
      `BC_CHK("wayField", d[19:18], way)
      `BC_CHK("subField", sb, sub)
    end
    arrayAck = ack;
    @(posedge clock);
    #1 arrayAck = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 20) begin
      @(posedge clock);
      #1 n++;
    end
    `BC_CHK("busy", 1'b0, busy)
    sTag = iTag;
    sData = iData;
    sTlb = iTlb;
    sMop = macro_op;
    sD = dRes;
    scramble();
  endtask : ix
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    req = '0;
    arrayAck = 1'b0;
    arstN = 1'b0;
    void'($urandom(32'h108bb411));
    scramble();
    repeat (5) @(posedge clock);
    #1 arstN = 1'b1;
    rd(`IRDR_SEL_I0, 64'h0);
    send(1'b1, 3'h0, 2'h1, {`IRDR_ID_ITAG, 24'h0});
    `BC_CHK("busy", 1'b0, busy)
    send(1'b0, `IRDR_SEL_I0, 2'h2, 32'h0);
    rd(3'h3, 64'h0);
    $display("test privilege done");
    ix(`IRDR_ID_ITAG, 2'h0, 1'b1);
    rd(`IRDR_SEL_I0, {32'h0, sTag});
    rd(`IRDR_SEL_I1, 64'h0);
    rd(`IRDR_SEL_I2, 64'h0);
    rd(`IRDR_SEL_I0, {32'h0, sTag});
    $display("test instruction tag done");
    ix(`IRDR_ID_IDATA, 2'h0, 1'b1);
    rd(`IRDR_SEL_I0, sData[63:0]);
    rd(`IRDR_SEL_I1, {44'h0, sData[83:64]});
    rd(`IRDR_SEL_I2, 64'h0);
    $display("test instruction data done");
    ix(`IRDR_ID_ITLB, 2'h0, 1'b1);
    rd(`IRDR_SEL_I0, sTlb & 64'hFBFC_00FF_FFFF_FFE1);
    ix(`IRDR_ID_MOP, 2'h0, 1'b1);
    rd(`IRDR_SEL_I0, sMop.word0);
    rd(`IRDR_SEL_I1, sMop.word1);
    rd(`IRDR_SEL_I2, sMop.word2);
    $display("test instruction tlb and macro_op done");
    ix(`IRDR_ID_DTAG, `IRDR_COPY_RSVD, 1'b0);
    rd(`IRDR_SEL_D0, 64'h0);
    for (int c = 0; c < 3; c++) begin
      ix(`IRDR_ID_DTAG, 2'(c), 1'b1);
      rd(`IRDR_SEL_D0, sD.word0);
    end
    ix(`IRDR_ID_DDATA, 2'($urandom), 1'b1);
    rd(`IRDR_SEL_D0, sD.word0);
    rd(`IRDR_SEL_D1, sD.word1);
    rd(`IRDR_SEL_D2, sD.word2);
    ix(`IRDR_ID_DTLB, 2'h0, 1'b1);
    rd(`IRDR_SEL_D0, sD.word0);
    ix(8'h02, 2'h0, 1'b1);
    rd(`IRDR_SEL_D0, 64'h0);
    $display("test data side done");
    repeat (3) @(posedge clock);
    stop_test();
  end
  // Whole sequence needs well under 2000 ns; a hang runs into this first
  initial begin
    #20000;
    miscompares++;
    stop_test();
  end
endmodule : internal_ram_debug_read_bench
